// >>> include/rxbo_pkg.sv
/*
 rxbo_pkg: register map, field widths and reset values of the receive
 offset / threshold block. Assumes a 32-bit APB register bus.
*/
package rxbo_pkg;
   localparam int unsigned NUM_CH      = 8;
   localparam int unsigned ADDR_W      = 12;
   // register byte addresses
   localparam logic [11:0] OFF_SKIP    = 12'h000;
   localparam logic [11:0] OFF_FILTER  = 12'h004;
   localparam logic [11:0] OFF_FLOWEN  = 12'h008;
   localparam logic [11:0] OFF_PAUSE0  = 12'h020;
   localparam logic [11:0] OFF_FREE0   = 12'h040;
   localparam logic [11:0] OFF_STATUS  = 12'h060;
   // field widths
   localparam int unsigned SKIP_W      = 16;
   localparam int unsigned LEVEL_W     = 8;
   localparam int unsigned FREE_W      = 16;
   // reset values
   localparam logic [15:0] SKIP_RST    = 16'h0000;
   localparam logic [7:0]  LEVEL_RST   = 8'h00;
   localparam logic [15:0] FREE_RST    = 16'h0000;
   localparam logic [7:0]  FLOWEN_RST  = 8'h00;
endpackage : rxbo_pkg

// >>> rtl/rxbo_level_mem.sv
/*
 rxbo_level_mem: per-channel 8-bit pause level store, registered read port.
 Assumes single clock, one write and one read address per cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module rxbo_level_mem
   import rxbo_pkg::*;
#(
   parameter int unsigned DEPTH = NUM_CH,
   parameter int unsigned WIDTH = LEVEL_W
) (
   // clock and reset
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   // write port
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
   input  wire logic [WIDTH-1:0]         wr_data,
   // read port
   input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
   output logic      [WIDTH-1:0]         rd_data,
   // all entries, for the comparators
   output logic      [DEPTH*WIDTH-1:0]   all_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= WIDTH'(LEVEL_RST);
         end
      end else if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem[rd_idx];
      end
   end

   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         all_data[i*WIDTH +: WIDTH] = mem[i];
      end
   end
endmodule : rxbo_level_mem
`default_nettype wire

// >>> rtl/rxbo_top.sv
/*
 rxbo_top: receive buffer offset, low-priority filter level, per-channel
 pause levels and free buffer counters behind an APB slave.
 Assumes the receive DMA reports frame completion and buffer use per channel.
*/
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module rxbo_top
   import rxbo_pkg::*;
#(
   parameter int unsigned CH = NUM_CH
) (
   // clock and reset
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // apb slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [ADDR_W-1:0]      paddr,
   input  wire logic [31:0]            pwdata,
   input  wire logic [3:0]             pstrb,
   output logic                        pready,
   output logic                        pslverr,
   output logic      [31:0]            prdata,
   // receive dma side
   input  wire logic                   sop_done,
   input  wire logic [$clog2(CH)-1:0]  sop_ch,
   input  wire logic                   frame_done,
   input  wire logic [$clog2(CH)-1:0]  frame_ch,
   input  wire logic [7:0]             frame_bufs,
   input  wire logic                   flow_global_en,
   // to descriptor writer and frame filter
   output logic                        sop_desc_we,
   output logic      [SKIP_W-1:0]      sop_desc_offset,
   output logic      [SKIP_W-1:0]      data_start_byte,
   output logic      [CH-1:0]          low_prio_drop,
   output logic      [CH-1:0]          flow_assert
);
   localparam int unsigned IW = $clog2(CH);

   logic [SKIP_W-1:0]      skip;
   logic [LEVEL_W-1:0]     filter_level;
   logic [CH-1:0]          flow_en;
   logic [FREE_W-1:0]      free_cnt [CH];
   logic [CH*LEVEL_W-1:0]  lvl_all;
   logic [31:0]            next_prdata;
   logic                   hit_err;

   // true when addr is an aligned word inside a per-channel window
   function automatic logic in_win(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] base);
      return (a >= base) && (a < base + ADDR_W'(4*CH)) && (a[1:0] == 2'b00);
   endfunction : in_win

   function automatic logic [IW-1:0] win_idx(input logic [ADDR_W-1:0] a,
                                             input logic [ADDR_W-1:0] base);
      logic [ADDR_W-1:0] d;
      d = a - base;
      return d[IW+1:2];
   endfunction : win_idx

   wire logic setup = psel && !penable;
   wire logic wr    = psel && penable && pwrite;
   wire logic lane0 = pstrb[0];
   wire logic lane1 = pstrb[1];

   // zero-wait access: data is ready after setup
   assign pready = 1'b1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         skip <= SKIP_RST;
      end else if (wr && paddr == OFF_SKIP) begin
         if (lane0) skip[7:0] <= pwdata[7:0];
         if (lane1) skip[15:8] <= pwdata[15:8];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filter_level <= LEVEL_RST;
      end else if (wr && paddr == OFF_FILTER && lane0) begin
         filter_level <= pwdata[LEVEL_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flow_en <= CH'(FLOWEN_RST);
      end else if (wr && paddr == OFF_FLOWEN && lane0) begin
         flow_en <= pwdata[CH-1:0];
      end
   end

   rxbo_level_mem #(
      .DEPTH (CH),
      .WIDTH (LEVEL_W)
   ) u_levels (
      .pclk     (pclk),
      .presetn  (presetn),
      .wr_en    (wr && in_win(paddr, OFF_PAUSE0) && lane0),
      .wr_idx   (win_idx(paddr, OFF_PAUSE0)),
      .wr_data  (pwdata[LEVEL_W-1:0]),
      .rd_idx   (win_idx(paddr, OFF_PAUSE0)),
      .rd_data  (),
      .all_data (lvl_all)
   );

   // free buffer counters, write adds, frame subtracts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < CH; i++) begin
            free_cnt[i] <= FREE_RST;
         end
      end else begin
         for (int i = 0; i < CH; i++) begin
            logic [FREE_W-1:0] add;
            logic [FREE_W-1:0] sub;
            add = '0;
            sub = '0;
            if (wr && in_win(paddr, OFF_FREE0) && win_idx(paddr, OFF_FREE0) == IW'(i)) begin
               add = {lane1 ? pwdata[15:8] : 8'h00, lane0 ? pwdata[7:0] : 8'h00};
            end
            if (frame_done && frame_ch == IW'(i)) begin
               sub = FREE_W'(frame_bufs);
            end
            // rolls over on overflow
            free_cnt[i] <= free_cnt[i] + add - sub;
         end
      end
   end

   always_comb begin
      for (int i = 0; i < CH; i++) begin
         logic [LEVEL_W-1:0] pl;
         pl = lvl_all[i*LEVEL_W +: LEVEL_W];
         low_prio_drop[i] = (filter_level != LEVEL_RST) &&
                            (free_cnt[i] <= FREE_W'(filter_level));
         flow_assert[i] = flow_global_en && flow_en[i] &&
                          (free_cnt[i] <= FREE_W'(pl));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sop_desc_we     <= 1'b0;
         sop_desc_offset <= SKIP_RST;
      end else begin
         sop_desc_we     <= sop_done;
         sop_desc_offset <= skip;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_start_byte <= SKIP_RST;
      end else begin
         data_start_byte <= skip;
      end
   end

   // read mux, reserved bits zero; level mem read arrives in access
   always_comb begin
      next_prdata = '0;
      hit_err     = 1'b0;
      if (paddr == OFF_SKIP) begin
         next_prdata[SKIP_W-1:0] = skip;
      end else if (paddr == OFF_FILTER) begin
         next_prdata[LEVEL_W-1:0] = filter_level;
      end else if (paddr == OFF_FLOWEN) begin
         next_prdata[CH-1:0] = flow_en;
      end else if (in_win(paddr, OFF_FREE0)) begin
         next_prdata[FREE_W-1:0] = free_cnt[win_idx(paddr, OFF_FREE0)];
      end else if (paddr == OFF_STATUS) begin
         next_prdata[CH-1:0]      = flow_assert;
         next_prdata[2*CH-1:CH]   = low_prio_drop;
      end else if (in_win(paddr, OFF_PAUSE0)) begin
         // taken from the stored entries so it lands with the setup edge
         next_prdata[LEVEL_W-1:0] = lvl_all[win_idx(paddr, OFF_PAUSE0)*LEVEL_W +: LEVEL_W];
      end else begin
         hit_err = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (setup) begin
         prdata <= next_prdata;
      end
   end

   logic err_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_q    <= 1'b0;
      end else if (setup) begin
         err_q    <= hit_err;
      end
   end

   // unmapped addresses answer with pslverr
   assign pslverr = psel && penable && err_q;
endmodule : rxbo_top
`default_nettype wire

// >>> tb/rxbo_sva.sv
/* rxbo_sva: port assertions for rxbo_top.
 assumes one clock and an async active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module rxbo_sva
   import rxbo_pkg::*;
#(
   parameter int unsigned CH = NUM_CH
) (
   // clock and reset
   input wire logic          pclk,
   input wire logic          presetn,
   // apb
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [11:0]   paddr,
   input wire logic [31:0]   pwdata,
   input wire logic [3:0]    pstrb,
   input wire logic          pslverr,
   input wire logic [31:0]   prdata,
   // dma side
   input wire logic          sop_done,
   input wire logic          flow_global_en,
   input wire logic          sop_desc_we,
   input wire logic [15:0]   data_start_byte,
   input wire logic [CH-1:0] low_prio_drop,
   input wire logic [CH-1:0] flow_assert
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_wr;
      psel && penable && pwrite && pstrb == 4'hf;
   endsequence
   a_sop_write: assert property (sop_done |=> sop_desc_we)
      else $error("no descriptor write after sop");
   a_sop_cause: assert property (sop_desc_we |-> $past(sop_done))
      else $error("descriptor write without sop");
   a_skip_start: assert property (s_wr ##0 paddr == OFF_SKIP |-> ##2 data_start_byte == $past(pwdata[15:0], 2))
      else $error("data start not the written skip");
   a_skip_rsvd: assert property (psel && penable && !pwrite && paddr == OFF_SKIP |-> prdata[31:16] == '0)
      else $error("skip upper bits not zero");
   a_level_rsvd: assert property (psel && penable && !pwrite && (paddr == OFF_FILTER || paddr[11:5] == 7'h01)
      |-> prdata[31:8] == '0)
      else $error("level upper bits not zero");
   a_filter_ok: assert property (psel && penable && paddr == OFF_FILTER |-> !pslverr)
      else $error("filter level access refused");
   a_flow_gate: assert property (!flow_global_en |-> flow_assert == '0)
      else $error("flow asserted while disabled");
   a_drop_zero: assert property (s_wr ##0 (paddr == OFF_FILTER && pwdata[7:0] == 8'h00) |=> low_prio_drop == '0)
      else $error("drop with zero filter level");
endmodule : rxbo_sva
bind rxbo_top rxbo_sva #(.CH(CH)) u_rxbo_sva (
   .pclk            (pclk),
   .presetn         (presetn),
   .psel            (psel),
   .penable         (penable),
   .pwrite          (pwrite),
   .paddr           (paddr),
   .pwdata          (pwdata),
   .pstrb           (pstrb),
   .pslverr         (pslverr),
   .prdata          (prdata),
   .sop_done        (sop_done),
   .flow_global_en  (flow_global_en),
   .sop_desc_we     (sop_desc_we),
   .data_start_byte (data_start_byte),
   .low_prio_drop   (low_prio_drop),
   .flow_assert     (flow_assert)
);
`default_nettype wire

// >>> tb/rxbo_tb_top.sv
/* rxbo_tb_top: self-checking bench for rxbo_top against a register model.
 assumes a zero-wait apb slave and one-cycle dma pulses. */
`timescale 1ns/10ps
`default_nettype none
module rxbo_tb_top import rxbo_pkg::*;;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        sop_done, frame_done, flow_global_en, sop_desc_we;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, d;
   logic [3:0]  pstrb;
   logic [2:0]  sop_ch, frame_ch;
   logic [7:0]  frame_bufs, low_prio_drop, flow_assert;
   logic [15:0] sop_desc_offset, data_start_byte;
   int          fails, compares, skip, lvl, flowen, c, b;
   int          pause [8];
   int          free [8];
   rxbo_top dut (
      .pclk            (pclk),
      .presetn         (presetn),
      .psel            (psel),
      .penable         (penable),
      .pwrite          (pwrite),
      .paddr           (paddr),
      .pwdata          (pwdata),
      .pstrb           (pstrb),
      .pready          (pready),
      .pslverr         (pslverr),
      .prdata          (prdata),
      .sop_done        (sop_done),
      .sop_ch          (sop_ch),
      .frame_done      (frame_done),
      .frame_ch        (frame_ch),
      .frame_bufs      (frame_bufs),
      .flow_global_en  (flow_global_en),
      .sop_desc_we     (sop_desc_we),
      .sop_desc_offset (sop_desc_offset),
      .data_start_byte (data_start_byte),
      .low_prio_drop   (low_prio_drop),
      .flow_assert     (flow_assert)
   );
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // apb master, one idle cycle after each transfer
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // no wait count assumed; only the watchdog ends a hung wait
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, '0);
      chk(rd, e);
   endtask : rdc
   task automatic set_regs(input int lim);
      d = $urandom;
      apb(1'b1, OFF_SKIP, d);
      skip = d[15:0];
      d = $urandom;
      apb(1'b1, OFF_FLOWEN, d);
      flowen = d[7:0];
      d = lim ? $urandom_range(lim) : $urandom;
      apb(1'b1, OFF_FILTER, d);
      lvl = d[7:0];
      for (int i = 0; i < 8; i++) begin
         d = lim ? $urandom_range(lim) : $urandom;
         apb(1'b1, OFF_PAUSE0 + 12'(4 * i), d);
         pause[i] = d[7:0];
      end
   endtask : set_regs
   task automatic check_regs();
      rdc(OFF_SKIP, skip);
      rdc(OFF_FILTER, lvl);
      rdc(OFF_FLOWEN, flowen);
      for (int i = 0; i < 8; i++)
         rdc(OFF_PAUSE0 + 12'(4 * i), pause[i]);
   endtask : check_regs
   task automatic chk_out();
      logic [7:0] ed;
      logic [7:0] ef;
      for (int i = 0; i < 8; i++) begin
         ed[i] = lvl != 0 && free[i] <= lvl;
         ef[i] = flow_global_en && flowen[i] && free[i] <= pause[i];
      end
      @(negedge pclk);
      chk(low_prio_drop, ed);
      chk(flow_assert, ef);
      @(posedge pclk);
      rdc(OFF_STATUS, {16'h0000, ed, ef});
   endtask : chk_out
   task automatic final_report();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // well above the thousand or fewer cycles the tests need
   initial begin
      #(20 * 20000);
      fails++;
      final_report();
   end
   initial begin
      {psel, penable, pwrite, sop_done, frame_done, flow_global_en} = '0;
      {paddr, pwdata, sop_ch, frame_ch, frame_bufs} = '0;
      pstrb = 4'hf;
      presetn = 1'b0;
      void'($urandom(48634));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check_regs();
      $display("test reset values done");
      set_regs(0);
      check_regs();
      apb(1'b0, 12'h100, '0);
      chk(err, 1'b1);
      chk(rd, '0);
      // lane 1 only: the low byte of the skip value must hold
      d = $urandom;
      pstrb <= 4'h2;
      apb(1'b1, OFF_SKIP, d);
      pstrb <= 4'hf;
      skip = {d[15:8], skip[7:0]};
      rdc(OFF_SKIP, skip);
      $display("test register access done");
      for (c = 0; c < 8; c++) begin
         sop_ch <= c[2:0];
         sop_done <= 1'b1;
         @(posedge pclk);
         sop_done <= 1'b0;
         @(negedge pclk);
         chk(sop_desc_we, 1'b1);
         chk(sop_desc_offset, skip);
         chk(data_start_byte, skip);
         @(posedge pclk);
      end
      $display("test descriptor offset done");
      set_regs(6);
      // early adds fill every channel so later frames rarely wrap
      for (c = 0; c < 60; c++) begin
         b = $urandom_range(c < 8 ? 9 : 3);
         d = c < 8 ? c : $urandom_range(7);
         flow_global_en <= 1'($urandom_range(1));
         if (c < 8 || $urandom_range(1)) begin
            apb(1'b1, OFF_FREE0 + 12'(4 * d), b);
            free[d] = (free[d] + b) % 65536;
         end else begin
            frame_ch <= d[2:0];
            frame_bufs <= b[7:0];
            frame_done <= 1'b1;
            @(posedge pclk);
            frame_done <= 1'b0;
            free[d] = (free[d] - b + 65536) % 65536;
         end
         chk_out();
         rdc(OFF_FREE0 + 12'(4 * d), free[d]);
      end
      apb(1'b1, OFF_FILTER, '0);
      lvl = 0;
      chk_out();
      $display("test thresholds done");
      final_report();
   end
endmodule : rxbo_tb_top
`default_nettype wire
